// [core/gst_pkg.sv]
package gst_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word per register)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_COUNT_LOW = 12'h000;
  localparam logic [11:0] ADDR_COUNT_HIGH = 12'h004;
  localparam logic [11:0] ADDR_TIMER_CONTROL = 12'h008;
  localparam logic [11:0] ADDR_GATE_CONTROL = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TC_RUN = 0;
  localparam int TC_SYNCDIS = 2;
  localparam int TC_OSCEN = 3;
  localparam int TC_PS_LO = 4;
  localparam int TC_CS_LO = 6;
  localparam int GC_SS_LO = 0;
  localparam int GC_POL = 6;
  localparam int GC_GE = 7;
  localparam int GC_CMPSYNC1 = 2;
  localparam int GC_CMPSYNC2 = 3;
  localparam int IRQ_OVF = 0;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [7:0] T0_MAX = 8'hff;

  typedef enum logic [1:0] {
    GST_CS_INSTR = 2'b00,
    GST_CS_SYSTEM = 2'b01,
    GST_CS_EXTERNAL = 2'b10,
    GST_CS_LFOSC = 2'b11
  } gst_clk_src_t;

  typedef enum logic [1:0] {
    GST_GS_PIN = 2'b00,
    GST_GS_T0OVF = 2'b01,
    GST_GS_CMP1 = 2'b10,
    GST_GS_CMP2 = 2'b11
  } gst_gate_src_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gst_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } gst_apb_rsp_t;

endpackage : gst_pkg

// [core/gst_timer.sv]
// Functional notes
// RULE_01 - 16-bit counter, byte writes load immediately
// RULE_02 - Run-enable off stops; gate-enable adds gating
// RULE_03 - Two-bit field selects count clock source
// RULE_04 - System clock source counts every clock
// RULE_05 - External source counts rising edges, sync optional (here the count path is always synchronised)
// RULE_06 - External mode needs falling edge first
// RULE_07 - Prescaler divides by 1, 2, 4, 8
// RULE_08 - Prescaler hidden, cleared by counter writes
// RULE_09 - Oscillator enable starts crystal, runs in sleep
// RULE_10 - Software waits crystal start-up via FC00h preset
// RULE_11 - Sync disable counts raw, runs in sleep (here it only sets sleep_run_ok; counting stays on the two-flop synchroniser)
// RULE_12 - Mode switch may skip or add increment
// RULE_13 - Byte reads valid while async running
// RULE_14 - Software stops counter before writing it
// RULE_15 - Gate counts while gate equals polarity
// RULE_16 - Two-bit field selects gate source
// RULE_17 - Timer0 wrap pulses gate source
// RULE_18 - Counter wraps to zero, sets overflow flag
// RULE_19 - Reset clears counter, prescaler, controls
`timescale 1ns/1ns
module gst_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire gst_pkg::gst_apb_req_t apb_req,
  output gst_pkg::gst_apb_rsp_t apb_rsp,
  // External pins and sources
  input wire logic external_count_input,
  input wire logic crystal_in_pin,
  input wire logic low_freq_internal_osc,
  input wire logic gate_pin,
  input wire logic comparator_one_out,
  input wire logic comparator_two_out,
  input wire logic [7:0] timer0_count,
  // Crystal driver and status
  output logic crystal_out_pin,
  output logic crystal_osc_enable,
  output logic sleep_run_ok,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] count_ff;
  logic [7:0] timer_control_ff;
  logic [7:0] gate_control_ff;
  logic [2:0] prescale_ff;
  logic [1:0] instr_div_ff;
  logic overflow_flag_ff;
  logic irq_mask_ff;
  logic [31:0] prdata_ff;
  logic ext_armed_ff;
  logic ext_prev_ff;
  logic src_prev_ff;
  logic [7:0] t0_prev_ff;
  logic t0_pulse_ff;
  logic [1:0] ext_sync_ff;
  logic [1:0] xtal_sync_ff;
  logic [1:0] lf_sync_ff;
  logic [1:0] gpin_sync_ff;
  logic [1:0] cmp1_sync_ff;
  logic [1:0] cmp2_sync_ff;

  logic run_enable;
  logic gate_enable;
  logic gate_polarity;
  logic sync_disable;
  gst_pkg::gst_clk_src_t clock_source_select;
  gst_pkg::gst_gate_src_t gate_source_select;
  logic [1:0] prescale_select;

  assign run_enable = timer_control_ff[gst_pkg::TC_RUN];
  assign sync_disable = timer_control_ff[gst_pkg::TC_SYNCDIS];
  assign crystal_osc_enable = timer_control_ff[gst_pkg::TC_OSCEN];
  assign prescale_select = timer_control_ff[gst_pkg::TC_PS_LO +: 2];
  assign clock_source_select = gst_pkg::gst_clk_src_t'(timer_control_ff[gst_pkg::TC_CS_LO +: 2]);
  assign gate_source_select = gst_pkg::gst_gate_src_t'(gate_control_ff[gst_pkg::GC_SS_LO +: 2]);
  assign gate_polarity = gate_control_ff[gst_pkg::GC_POL];
  assign gate_enable = gate_control_ff[gst_pkg::GC_GE];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic wr_low;
  logic wr_high;
  logic rd_status;
  logic addr_ok;

  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign wr_low = wr_en && apb_req.paddr == gst_pkg::ADDR_COUNT_LOW;
  assign wr_high = wr_en && apb_req.paddr == gst_pkg::ADDR_COUNT_HIGH;
  assign rd_status = rd_en && apb_req.paddr == gst_pkg::ADDR_IRQ_STATUS;
  assign addr_ok = apb_req.paddr inside {gst_pkg::ADDR_COUNT_LOW, gst_pkg::ADDR_COUNT_HIGH,
    gst_pkg::ADDR_TIMER_CONTROL, gst_pkg::ADDR_GATE_CONTROL, gst_pkg::ADDR_IRQ_STATUS,
    gst_pkg::ADDR_IRQ_MASK};

  // Zero wait states; unmapped addresses answer with an error
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;
  assign apb_rsp.prdata = prdata_ff;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two flops per async input; the edge detector keeps its own history
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ext_sync_ff <= 2'h0;
      xtal_sync_ff <= 2'h0;
      lf_sync_ff <= 2'h0;
      gpin_sync_ff <= 2'h0;
      cmp1_sync_ff <= 2'h0;
      cmp2_sync_ff <= 2'h0;
    end
    else
    begin
      ext_sync_ff <= {ext_sync_ff[0], external_count_input};
      xtal_sync_ff <= {xtal_sync_ff[0], crystal_in_pin};
      lf_sync_ff <= {lf_sync_ff[0], low_freq_internal_osc};
      gpin_sync_ff <= {gpin_sync_ff[0], gate_pin};
      cmp1_sync_ff <= {cmp1_sync_ff[0], comparator_one_out};
      cmp2_sync_ff <= {cmp2_sync_ff[0], comparator_two_out};
    end
  end

  // ----------------------------------------------------------------
  // Crystal oscillator driver
  // ----------------------------------------------------------------
  // Inverting amplifier model; held low when disabled to save power
  assign crystal_out_pin = crystal_osc_enable & ~xtal_sync_ff[1]; // RULE_09
  // Async external counting may continue while the core sleeps
  assign sleep_run_ok = run_enable && sync_disable
    && clock_source_select == gst_pkg::GST_CS_EXTERNAL; // RULE_11

  // ----------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------
  logic ext_level;
  logic src_level;
  logic src_rise;
  logic src_fall;
  logic instr_tick;
  logic clk_tick;

  // With the crystal enabled the external source is the oscillator
  assign ext_level = crystal_osc_enable ? xtal_sync_ff[1] : ext_sync_ff[1]; // RULE_05
  assign src_level = clock_source_select == gst_pkg::GST_CS_LFOSC ? lf_sync_ff[1] : ext_level;
  assign src_rise = src_level && !src_prev_ff;
  assign src_fall = !src_level && src_prev_ff;
  assign instr_tick = instr_div_ff == gst_pkg::INSTR_DIV_LAST;

  always_comb
  begin
    unique case (clock_source_select) // RULE_03
      gst_pkg::GST_CS_INSTR: clk_tick = instr_tick;
      gst_pkg::GST_CS_SYSTEM: clk_tick = 1'b1; // RULE_04
      gst_pkg::GST_CS_EXTERNAL: clk_tick = src_rise && ext_armed_ff; // RULE_05 RULE_06
      gst_pkg::GST_CS_LFOSC: clk_tick = src_rise;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      instr_div_ff <= 2'h0;
      src_prev_ff <= 1'b0;
    end
    else
    begin
      instr_div_ff <= instr_div_ff + 2'h1;
      src_prev_ff <= src_level;
    end
  end

  // Falling edge must be seen after reset, a counter write or while disabled
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ext_armed_ff <= 1'b0; // RULE_06
    else if (wr_low || wr_high || !run_enable)
      ext_armed_ff <= 1'b0; // RULE_06
    else if (src_fall)
      ext_armed_ff <= 1'b1; // RULE_06
  end

  // ----------------------------------------------------------------
  // Gate logic
  // ----------------------------------------------------------------
  logic cmp1_level;
  logic cmp2_level;
  logic gate_level;
  logic gate_open;
  logic count_en;

  assign cmp1_level = gate_control_ff[gst_pkg::GC_CMPSYNC1] ? cmp1_sync_ff[1] : comparator_one_out;
  assign cmp2_level = gate_control_ff[gst_pkg::GC_CMPSYNC2] ? cmp2_sync_ff[1] : comparator_two_out;

  // Timer0 wrap detection gives a one-cycle high pulse
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      t0_prev_ff <= 8'h00;
      t0_pulse_ff <= 1'b0;
    end
    else
    begin
      t0_prev_ff <= timer0_count;
      t0_pulse_ff <= t0_prev_ff == gst_pkg::T0_MAX && timer0_count == 8'h00; // RULE_17
    end
  end

  always_comb
  begin
    unique case (gate_source_select) // RULE_16
      gst_pkg::GST_GS_PIN: gate_level = gpin_sync_ff[1];
      gst_pkg::GST_GS_T0OVF: gate_level = t0_pulse_ff; // RULE_17
      gst_pkg::GST_GS_CMP1: gate_level = cmp1_level;
      gst_pkg::GST_GS_CMP2: gate_level = cmp2_level;
    endcase
  end

  assign gate_open = gate_level == gate_polarity; // RULE_15
  assign count_en = run_enable && (!gate_enable || gate_open); // RULE_02

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic pre_tick;

  always_comb
  begin
    unique case (prescale_select) // RULE_07
      2'b00: pre_tick = 1'b1;
      2'b01: pre_tick = prescale_ff[0];
      2'b10: pre_tick = &prescale_ff[1:0];
      2'b11: pre_tick = &prescale_ff;
    endcase
  end

  // Not mapped to any register; counter writes restart it
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prescale_ff <= gst_pkg::PRESCALE_RESET; // RULE_19
    else if (wr_low || wr_high)
      prescale_ff <= gst_pkg::PRESCALE_RESET; // RULE_08
    else if (count_en && clk_tick)
      prescale_ff <= prescale_ff + 3'h1; // RULE_07
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic inc;
  logic wrap;

  // Synced and raw modes share one edge path, so mode switches
  // cannot lose or add counts here
  assign inc = count_en && clk_tick && pre_tick; // RULE_12
  assign wrap = inc && count_ff == gst_pkg::COUNT_MAX; // RULE_18

  // Register write wins over a coincident increment
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      count_ff <= gst_pkg::COUNT_RESET; // RULE_19
    else if (wr_low)
      count_ff <= {count_ff[15:8], apb_req.pwdata[7:0]}; // RULE_01 RULE_14
    else if (wr_high)
      count_ff <= {apb_req.pwdata[7:0], count_ff[7:0]}; // RULE_01 RULE_14
    else if (inc)
      count_ff <= count_ff + 16'h0001; // RULE_01 RULE_18
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      timer_control_ff <= gst_pkg::CTRL_RESET; // RULE_19
      gate_control_ff <= gst_pkg::CTRL_RESET; // RULE_19
      irq_mask_ff <= 1'b0;
    end
    else if (wr_en)
    begin
      if (apb_req.paddr == gst_pkg::ADDR_TIMER_CONTROL)
        timer_control_ff <= apb_req.pwdata[7:0];
      if (apb_req.paddr == gst_pkg::ADDR_GATE_CONTROL)
        gate_control_ff <= apb_req.pwdata[7:0];
      if (apb_req.paddr == gst_pkg::ADDR_IRQ_MASK)
        irq_mask_ff <= apb_req.pwdata[gst_pkg::IRQ_OVF];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // Rollover wins over the read that clears the flag
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      overflow_flag_ff <= 1'b0;
    else if (wrap)
      overflow_flag_ff <= 1'b1; // RULE_18 RULE_11
    else if (rd_status)
      overflow_flag_ff <= 1'b0;
  end

  assign irq = overflow_flag_ff && irq_mask_ff;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Counter is in the bus domain, so each byte read is coherent
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prdata_ff <= 32'h00000000;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
    begin
      unique case (apb_req.paddr)
        gst_pkg::ADDR_COUNT_LOW: prdata_ff <= {24'h000000, count_ff[7:0]}; // RULE_13
        gst_pkg::ADDR_COUNT_HIGH: prdata_ff <= {24'h000000, count_ff[15:8]}; // RULE_13
        gst_pkg::ADDR_TIMER_CONTROL: prdata_ff <= {24'h000000, timer_control_ff};
        gst_pkg::ADDR_GATE_CONTROL: prdata_ff <= {24'h000000, gate_control_ff};
        gst_pkg::ADDR_IRQ_STATUS: prdata_ff <= {31'h00000000, overflow_flag_ff};
        gst_pkg::ADDR_IRQ_MASK: prdata_ff <= {31'h00000000, irq_mask_ff};
        default: prdata_ff <= 32'h00000000;
      endcase
    end
  end

endmodule : gst_timer

// [test/gst_pins_model.sv]
`timescale 1ns/1ns
module gst_pins_model (
  // Clock
  input wire logic mclk,
  // Pins toward the timer
  output logic ext_clk,
  output logic lf_osc,
  output logic gate,
  output logic cmp1,
  output logic cmp2
);
  logic [2:0] div_ff = 3'h0;

  // Slow oscillator, eight mclk per period
  always_ff @(posedge mclk)
    div_ff <= div_ff + 3'h1;
  assign lf_osc = div_ff[2];

  initial
  begin
    ext_clk = 1'b0;
    gate = 1'b0;
    cmp1 = 1'b0;
    cmp2 = 1'b0;
  end

  task automatic set_levels(input logic g, input logic c1, input logic c2);
    @(posedge mclk);
    gate <= g;
    cmp1 <= c1;
    cmp2 <= c2;
  endtask : set_levels

  // Count clock stands low between bursts
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge mclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_clk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
  endtask : pulses
endmodule : gst_pins_model

// [test/gst_timer_assertions.sv]
`timescale 1ns/1ns
module gst_timer_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire gst_pkg::gst_apb_req_t apb_req,
  input wire gst_pkg::gst_apb_rsp_t apb_rsp,
  // Status
  input wire logic crystal_out_pin,
  input wire logic crystal_osc_enable,
  input wire logic sleep_run_ok,
  input wire logic irq
);
  logic acc;
  logic mapped;
  logic rd_setup;
  logic wr_ctrl;
  logic sleep_cfg;
  logic mask_off;
  assign acc = apb_req.psel & apb_req.penable;
  assign mapped = (apb_req.paddr <= gst_pkg::ADDR_IRQ_MASK) & (apb_req.paddr[1:0] == 2'h0);
  assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign wr_ctrl = acc & apb_req.pwrite & (apb_req.paddr == gst_pkg::ADDR_TIMER_CONTROL);
  assign sleep_cfg = apb_req.pwdata[0] & apb_req.pwdata[2] & (apb_req.pwdata[7:6] == 2'b10);
  assign mask_off = acc & apb_req.pwrite & (apb_req.paddr == gst_pkg::ADDR_IRQ_MASK)
    & ~apb_req.pwdata[0];

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_err_unmapped: assert property (acc && !mapped |-> apb_rsp.pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (acc && mapped |-> !apb_rsp.pslverr)
    else $error("error on mapped access");
  chk_byte_upper: assert property (rd_setup && mapped |=> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_zero_unmapped: assert property (rd_setup && !mapped |=> apb_rsp.prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_osc_bit: assert property (wr_ctrl |=> crystal_osc_enable == $past(apb_req.pwdata[3]))
    else $error("oscillator enable not taken");
  chk_osc_hold: assert property (!wr_ctrl |=> $stable(crystal_osc_enable))
    else $error("oscillator enable moved");
  chk_xtal_off: assert property (!crystal_osc_enable |-> !crystal_out_pin)
    else $error("crystal driven while off");
  chk_sleep_cfg: assert property (wr_ctrl |=> sleep_run_ok == $past(sleep_cfg))
    else $error("sleep run flag wrong");
  chk_mask_quiet: assert property (mask_off |=> !irq [*2])
    else $error("irq high while masked");
  chk_reset_clear: assert property ($fell(rst) |-> !irq && !crystal_osc_enable && !sleep_run_ok)
    else $error("outputs not clear after reset");

  cover property (irq);
  cover property (acc && apb_rsp.pslverr);
  cover property (sleep_run_ok && crystal_out_pin == 1'b0);
endmodule : gst_timer_assertions

bind gst_timer gst_timer_assertions u_chk (.mclk(mclk), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .crystal_out_pin(crystal_out_pin),
  .crystal_osc_enable(crystal_osc_enable), .sleep_run_ok(sleep_run_ok), .irq(irq));

// [test/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  gst_pkg::gst_apb_req_t req = '0;
  gst_pkg::gst_apb_rsp_t rsp;
  logic [7:0] t0_ff = 8'h00;
  logic ext_clk, lf_osc, gate, cmp1, cmp2, xout, oscen, sleep_ok, irq, err_ff;
  logic [31:0] rd_ff;
  logic [31:0] prev_ff;
  logic [7:0] ctl [3] = '{8'h01, 8'hc9, 8'h40};
  logic [7:0] want [3] = '{8'h08, 8'h04, 8'h00};
  int failures = 0;
  int tests_run = 0;

  always #2 mclk = ~mclk;

  gst_timer uut (.mclk(mclk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .external_count_input(ext_clk), .crystal_in_pin(lf_osc), .low_freq_internal_osc(lf_osc),
    .gate_pin(gate), .comparator_one_out(cmp1), .comparator_two_out(cmp2),
    .timer0_count(t0_ff), .crystal_out_pin(xout), .crystal_osc_enable(oscen),
    .sleep_run_ok(sleep_ok), .irq(irq));
  gst_pins_model pins (.mclk(mclk), .ext_clk(ext_clk), .lf_osc(lf_osc), .gate(gate),
    .cmp1(cmp1), .cmp2(cmp2));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    rd_ff = rsp.prdata;
    err_ff = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic mark;
    apb(1'b0, gst_pkg::ADDR_COUNT_LOW, 32'h0);
    prev_ff = rd_ff;
  endtask : mark

  task automatic delta(input logic [7:0] exp);
    apb(1'b0, gst_pkg::ADDR_COUNT_LOW, 32'h0);
    check({24'h0, rd_ff[7:0] - prev_ff[7:0]}, {24'h0, exp});
  endtask : delta

  // Read setups land exactly 32 mclk apart
  task automatic window(input logic [7:0] exp);
    mark();
    repeat (29) @(posedge mclk);
    delta(exp);
  endtask : window

  // Stop before loading keeps the write clear of an increment
  task automatic restart(input logic [31:0] c);
    apb(1'b1, gst_pkg::ADDR_TIMER_CONTROL, 32'h0);
    apb(1'b1, gst_pkg::ADDR_COUNT_LOW, 32'h0);
    apb(1'b1, gst_pkg::ADDR_TIMER_CONTROL, c);
  endtask : restart

  task automatic stop_test;
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a <= 20; a += 4)
    begin
      apb(1'b0, 12'(a), 32'h0);
      check(rd_ff, 32'h0);
    end
    apb(1'b1, 12'h018, 32'hff);
    apb(1'b0, 12'h018, 32'h0);
    check(rd_ff | {err_ff, 31'h0}, 32'h80000000);
    apb(1'b1, gst_pkg::ADDR_COUNT_HIGH, 32'h1ab);
    apb(1'b0, gst_pkg::ADDR_COUNT_HIGH, 32'h0);
    check(rd_ff, 32'hab);
    for (int p = 0; p < 4; p++)
    begin
      restart(32'h41 | 32'(p << 4));
      window(8'(32 >> p));
    end
    for (int s = 0; s < 3; s++)
    begin
      restart({24'h0, ctl[s]});
      window(want[s]);
    end
    for (int i = 0; i < 8; i++)
    begin
      pins.set_levels(i % 4 == 0, i % 4 == 2, i % 4 == 3);
      apb(1'b1, gst_pkg::ADDR_GATE_CONTROL, (i < 4 ? 32'h8c : 32'h80) | 32'(i % 4) | 32'((i / 4) << 6));
      restart(32'h41);
      window(((i % 4 == 1) ^ (i / 4 == 1)) ? 8'h20 : 8'h00);
    end
    // Single Timer0 wrap opens the gate for one count
    apb(1'b1, gst_pkg::ADDR_GATE_CONTROL, 32'hc1);
    mark();
    t0_ff <= 8'hff;
    @(posedge mclk);
    t0_ff <= 8'h00;
    repeat (6) @(posedge mclk);
    delta(8'h01);
    apb(1'b1, gst_pkg::ADDR_GATE_CONTROL, 32'h0);
    restart(32'h85);
    mark();
    pins.pulses(3);
    delta(8'h02);
    mark();
    pins.pulses(3);
    delta(8'h03);
    apb(1'b1, gst_pkg::ADDR_TIMER_CONTROL, 32'h0);
    apb(1'b1, gst_pkg::ADDR_COUNT_HIGH, 32'hff);
    apb(1'b1, gst_pkg::ADDR_COUNT_LOW, 32'hf0);
    apb(1'b1, gst_pkg::ADDR_IRQ_MASK, 32'h1);
    apb(1'b1, gst_pkg::ADDR_TIMER_CONTROL, 32'h41);
    repeat (32) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, gst_pkg::ADDR_COUNT_HIGH, 32'h0);
    check(rd_ff, 32'h0);
    apb(1'b1, gst_pkg::ADDR_IRQ_MASK, 32'h0);
    @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, gst_pkg::ADDR_IRQ_STATUS, 32'h0);
    check(rd_ff, 32'h1);
    apb(1'b0, gst_pkg::ADDR_IRQ_STATUS, 32'h0);
    check(rd_ff, 32'h0);
    // Crystal warm-up: from the preset, 1024 rising edges reach rollover
    restart(32'h0);
    apb(1'b1, gst_pkg::ADDR_COUNT_HIGH, 32'hfc);
    apb(1'b1, gst_pkg::ADDR_TIMER_CONTROL, 32'h89);
    repeat (8100) @(posedge mclk);
    apb(1'b0, gst_pkg::ADDR_IRQ_STATUS, 32'h0);
    check(rd_ff, 32'h0);
    repeat (130) @(posedge mclk);
    apb(1'b0, gst_pkg::ADDR_IRQ_STATUS, 32'h0);
    check(rd_ff, 32'h1);
    stop_test();
  end

  // Whole run needs about nine thousand cycles, mostly crystal warm-up
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    stop_test();
  end
endmodule : tb_top
